// ==== shared/hbr_pkg.sv ====
package hbr_pkg;
  // word geometry
  localparam int unsigned NUM_OUT      = 12;
  localparam int unsigned NUM_PAIRS    = 6;
  localparam int unsigned FRAME_BITS   = 16;
  localparam logic [3:0]  LAST_BIT     = 4'hF;
  localparam logic [3:0]  FIRST_BIT    = 4'h0;
  // command word fields
  localparam int unsigned CMD_SRR      = 0;
  localparam int unsigned CMD_OUT_LSB  = 1;
  localparam int unsigned CMD_OUT_MSB  = 12;
  localparam int unsigned CMD_OCD_EN   = 13;
  localparam int unsigned CMD_ULD_EN   = 14;
  localparam int unsigned CMD_OVERVOLTAGE_SHUTDOWN_ENABLE_EN  = 15;
  // returned status word fields
  localparam int unsigned STAT_TW      = 0;
  localparam int unsigned STAT_OUT_LSB = 1;
  localparam int unsigned STAT_OUT_MSB = 12;
  localparam int unsigned STAT_OLD     = 13;
  localparam int unsigned STAT_ULD     = 14;
  localparam int unsigned STAT_PSF     = 15;
  // timing
  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned ULD_DELAY_NS_DEF = 200000;
  // synchroniser reset levels: serial group {chip_select_n, sclk, sdi}
  localparam logic [2:0]  SPI_SYNC_RST = 3'h4;
endpackage : hbr_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// three-stage synchroniser with agreement filter on stages two and three
module pin_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // s1 feeds only s2; the filter looks at s2 and s3
  always_comb begin
    next_st    = st;
    next_st.s1 = pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q  = (st.q & (st.s2 ^ st.s3)) | (st.s3 & ~(st.s2 ^ st.s3));
  end

  // constant reset so idle pins do not fake an edge at release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st <= next_st;
    end
  end

  assign level = st.q;
endmodule : pin_sync
`default_nettype wire

// ==== rtl/serial_frame.sv ====
`timescale 1ns/10ps
`default_nettype none
// serial shifter: lsb first, sample on sclk fall, shift out on sclk rise
module serial_frame (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        hold,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        sdi,
  input  wire logic [15:0] status_word,
  output logic      [15:0] frame_word,
  output logic             frame_ok,
  output logic             sdo,
  output logic             sdo_oe
);
  import hbr_pkg::*;

  typedef struct packed {
    logic        cs_d;
    logic        sclk_d;
    logic [15:0] shreg;
    logic [3:0]  bitcnt;
    logic        got_word;
    logic [15:0] word;
    logic        ok;
    logic        sdo;
    logic        sdo_oe;
  } frame_s;

  localparam frame_s FRAME_RST = '{cs_d: 1'b1, default: '0};

  frame_s st;
  frame_s next_st;

  // edge detection on filtered levels; the shift register doubles as daisy chain path
  always_comb begin
    next_st        = st;
    next_st.ok     = 1'b0;
    next_st.cs_d   = cs_n;
    next_st.sclk_d = sclk;
    if (hold) begin
      next_st        = FRAME_RST;
      next_st.cs_d   = cs_n;
      next_st.sclk_d = sclk;
    end else if (st.cs_d && !cs_n) begin
      next_st.shreg    = status_word;
      next_st.bitcnt   = FIRST_BIT;
      next_st.got_word = 1'b0;
      next_st.sdo      = status_word[STAT_TW];
      next_st.sdo_oe   = 1'b1;
    end else if (!st.cs_d && cs_n) begin
      next_st.sdo_oe = 1'b0;
      next_st.sdo    = 1'b0;
      // whole multiples of 16 only; partial frames vanish
      if (st.bitcnt == FIRST_BIT && st.got_word) begin
        next_st.ok   = 1'b1;
        next_st.word = st.shreg;
      end
    end else if (!cs_n) begin
      if (st.sclk_d && !sclk) begin
        next_st.shreg  = {sdi, st.shreg[15:1]};
        next_st.bitcnt = 4'(st.bitcnt + 4'h1);
        if (st.bitcnt == LAST_BIT) begin
          next_st.got_word = 1'b1;
        end
      end else if (!st.sclk_d && sclk) begin
        next_st.sdo = st.shreg[0];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= FRAME_RST;
    end else begin
      st <= next_st;
    end
  end

  assign frame_word = st.word;
  assign frame_ok   = st.ok;
  assign sdo        = st.sdo;
  assign sdo_oe     = st.sdo_oe;

  // tristate as soon as chip select is seen high
  AST_SDO_OFF_CS_HIGH: assert property (
    @(posedge mclk) disable iff (rst) (!st.cs_d && cs_n) |=> !sdo_oe)
    else $error("sdo still driven after cs rise");
  AST_TW_ON_CS_FALL: assert property (
    @(posedge mclk) disable iff (rst)
    (st.cs_d && !cs_n && !hold) |=> (sdo_oe && sdo == $past(status_word[STAT_TW])))
    else $error("thermal warning not shown at cs fall");
  AST_PARTIAL_DROP: assert property (
    @(posedge mclk) disable iff (rst)
    (!st.cs_d && cs_n && st.bitcnt != FIRST_BIT) |=> !frame_ok)
    else $error("partial frame applied");
  COV_FRAME_OK: cover property (@(posedge mclk) disable iff (rst) frame_ok);
endmodule : serial_frame
`default_nettype wire

// ==== rtl/hex_half_bridge_fault_control.sv ====
// Operation
// - sleep clears all command and status state
// - outputs start off at power-up
// - logic supply reset; frames only after lockout release
// - output stays on until undervoltage, command, fault
// - state kept across driver supply range
// - overcurrent sets sticky overload bit 13
// - overcurrent enable latches output off until clear
// - no output on above over-temperature level
// - long under-load sets sticky bit 14
// - under-load enable latches offending output off
// - overvoltage sets sticky supply fail bit 15
// - overvoltage enable gates outputs, pattern kept
// - thermal warning sets bit 0, outputs stay
// - any sensor over-temperature turns all off
// - warning bit sticky until status clear
// - warning bit on serial out at cs fall
// - twelve outputs independent, no interlock
// - 16-bit frames, lsb first, falling-edge sampling
// - apply only whole multiples of 16 bits
// - status bits 1-12 mirror outputs, daisy chain
// - serial out high impedance while cs high
`timescale 1ns/10ps
`default_nettype none
module hex_half_bridge_fault_control #(
  parameter int unsigned ULD_DELAY_NS = hbr_pkg::ULD_DELAY_NS_DEF
) (
  input  wire logic                             mclk,
  input  wire logic                             rst,
  input  wire logic                             sleep_enable,
  input  wire logic                             logic_supply_ok,
  input  wire logic                             undervoltage_lockout,
  input  wire logic                             driver_supply_a_ov,
  input  wire logic                             driver_supply_b_ov,
  input  wire logic [hbr_pkg::NUM_OUT-1:0]      overcurrent,
  input  wire logic [hbr_pkg::NUM_OUT-1:0]      underload,
  input  wire logic [hbr_pkg::NUM_PAIRS-1:0]    thermal_warning,
  input  wire logic [hbr_pkg::NUM_PAIRS-1:0]    over_temperature,
  input  wire logic                             chip_select_n,
  input  wire logic                             sclk,
  input  wire logic                             sdi,
  output logic      [hbr_pkg::NUM_PAIRS-1:0]    high_side_output,
  output logic      [hbr_pkg::NUM_PAIRS-1:0]    low_side_output,
  output logic                                  sdo,
  output logic                                  sdo_oe
);
  import hbr_pkg::*;

  // under-load delay: a least time, so round up
  localparam int unsigned ULD_CYC_INT = (ULD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CW          = $clog2(ULD_CYC_INT + 1);
  localparam logic [CW-1:0] ULD_CYC   = CW'(ULD_CYC_INT);
  localparam int unsigned FAULT_W     = 5 + 2 * NUM_OUT + 2 * NUM_PAIRS;

  typedef struct packed {
    logic [NUM_OUT-1:0]         prog;
    logic                       ocd_en;
    logic                       uld_en;
    logic                       overvoltage_shutdown_enable_en;
    logic [NUM_OUT-1:0]         latched_off;
    logic                       tw;
    logic                       old;
    logic                       underload_shutdown_and_status;
    logic                       supply_fail_status;
    logic [NUM_OUT-1:0][CW-1:0] uld_cnt;
    logic [NUM_OUT-1:0]         drive;
  } ctl_s;

  ctl_s st;
  ctl_s next_st;

  // synchronised pins
  logic                 en_s;
  logic                 vcc_ok_s;
  logic                 uv_s;
  logic                 ova_s;
  logic                 ovb_s;
  logic [NUM_OUT-1:0]   oc_s;
  logic [NUM_OUT-1:0]   ul_s;
  logic [NUM_PAIRS-1:0] warn_s;
  logic [NUM_PAIRS-1:0] ot_s;
  logic                 cs_s;
  logic                 sclk_s;
  logic                 sdi_s;

  // serial side
  logic        hold;
  logic [15:0] status_word;
  logic [15:0] frame_word;
  logic        frame_ok;
  logic        clr;
  logic [NUM_OUT-1:0] uld_hit;
  logic [NUM_OUT-1:0] gate_off;

  // fault and supply pins share one synchroniser, idle level zero
  pin_sync #(
    .W       (FAULT_W),
    .RST_VAL ('0)
  ) u_fault_sync (
    .mclk  (mclk),
    .rst   (rst),
    .pin   ({sleep_enable, logic_supply_ok, undervoltage_lockout, driver_supply_a_ov,
             driver_supply_b_ov, overcurrent, underload, thermal_warning, over_temperature}),
    .level ({en_s, vcc_ok_s, uv_s, ova_s, ovb_s, oc_s, ul_s, warn_s, ot_s})
  );

  // serial pins; chip select resets high so release makes no false frame
  pin_sync #(
    .W       (3),
    .RST_VAL (SPI_SYNC_RST)
  ) u_spi_sync (
    .mclk  (mclk),
    .rst   (rst),
    .pin   ({chip_select_n, sclk, sdi}),
    .level ({cs_s, sclk_s, sdi_s})
  );

  // sleep or logic supply lockout wipes everything and blocks frames
  assign hold = !en_s || !vcc_ok_s;

  // status word mirrors live output state; built from registers only
  always_comb begin
    status_word                             = '0;
    status_word[STAT_TW]                    = st.tw;
    status_word[STAT_OUT_MSB:STAT_OUT_LSB]  = st.drive;
    status_word[STAT_OLD]                   = st.old;
    status_word[STAT_ULD]                   = st.underload_shutdown_and_status;
    status_word[STAT_PSF]                   = st.supply_fail_status;
  end

  serial_frame u_frame (
    .mclk        (mclk),
    .rst         (rst),
    .hold        (hold),
    .cs_n        (cs_s),
    .sclk        (sclk_s),
    .sdi         (sdi_s),
    .status_word (status_word),
    .frame_word  (frame_word),
    .frame_ok    (frame_ok),
    .sdo         (sdo),
    .sdo_oe      (sdo_oe)
  );

  // pick one side out of the interleaved output vector
  function automatic logic [NUM_PAIRS-1:0] side_bits(input logic [NUM_OUT-1:0] v,
                                                      input logic hi);
    logic [NUM_PAIRS-1:0] r;
    r = '0;
    for (int k = 0; k < NUM_PAIRS; k++) begin
      r[k] = v[2 * k + (hi ? 1 : 0)];
    end
    return r;
  endfunction : side_bits

  assign clr = frame_ok && frame_word[CMD_SRR];

  // fault flags, latches, under-load timers and the output gate
  always_comb begin
    next_st = st;
    uld_hit = '0;
    // under-load must persist past the delay while the output is on
    for (int i = 0; i < NUM_OUT; i++) begin
      if (st.drive[i] && ul_s[i]) begin
        if (st.uld_cnt[i] < ULD_CYC) begin
          next_st.uld_cnt[i] = CW'(st.uld_cnt[i] + 1'b1);
        end else begin
          uld_hit[i] = 1'b1;
        end
      end else begin
        next_st.uld_cnt[i] = '0;
      end
    end
    // sticky flags: a new event wins over a clear in the same cycle
    next_st.old = (st.old && !clr) || |(oc_s & st.drive);
    next_st.underload_shutdown_and_status = (st.underload_shutdown_and_status && !clr) || |uld_hit;
    next_st.supply_fail_status = (st.supply_fail_status && !clr) || ova_s || ovb_s || uv_s;
    next_st.tw  = (st.tw && !clr) || |warn_s;
    next_st.latched_off = (st.latched_off & {NUM_OUT{!clr}})
                        | (st.ocd_en ? (oc_s & st.drive) : '0)
                        | (st.uld_en ? uld_hit : '0);
    if (frame_ok) begin
      next_st.prog    = frame_word[CMD_OUT_MSB:CMD_OUT_LSB];
      next_st.ocd_en  = frame_word[CMD_OCD_EN];
      next_st.uld_en  = frame_word[CMD_ULD_EN];
      next_st.overvoltage_shutdown_enable_en = frame_word[CMD_OVERVOLTAGE_SHUTDOWN_ENABLE_EN];
    end
    // gates leave prog untouched, so outputs return on recovery
    gate_off = {NUM_OUT{uv_s
             || (|ot_s)
             || (next_st.overvoltage_shutdown_enable_en && (ova_s || ovb_s))}};
    next_st.drive = next_st.prog & ~next_st.latched_off & ~gate_off;
    if (hold) begin
      next_st = '0;
    end
  end

  // all outputs off from reset onward
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // no interlock between the two switches of a pair; the host owns that
  assign low_side_output  = side_bits(st.drive, 1'b0);
  assign high_side_output = side_bits(st.drive, 1'b1);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // wipe, lockout and supply gating; reset is watched even while it is high
  AST_RESET_OFF: assert property (
    @(posedge mclk) disable iff (1'b0)
    rst |=> (low_side_output == '0 && high_side_output == '0))
    else $error("output on straight after reset");
  AST_SLEEP_WIPES: assert property (
    !en_s |=> (st.prog == '0 && !st.tw && st.drive == '0))
    else $error("sleep did not clear state");
  AST_LOCKOUT_OFF: assert property (
    !vcc_ok_s |=> (!frame_ok && st.prog == '0))
    else $error("frame taken under logic lockout");
  AST_UV_OFF: assert property (
    uv_s |=> (low_side_output == '0 && high_side_output == '0))
    else $error("output on under driver undervoltage");
  // an output that nothing turns off may only gain neighbours, never drop
  AST_ON_STAYS_ON: assert property (
    (!hold && !frame_ok && !uv_s && !(|ot_s) && !(st.overvoltage_shutdown_enable_en && (ova_s || ovb_s))
     && !(|oc_s) && !(|uld_hit))
    |=> ((st.drive & $past(st.drive)) == $past(st.drive)))
    else $error("output dropped with no cause");
  AST_FRAME_APPLIES: assert property (
    (frame_ok && !hold)
    |=> (st.prog == $past(frame_word[CMD_OUT_MSB:CMD_OUT_LSB])
         && st.ocd_en == $past(frame_word[CMD_OCD_EN])
         && st.uld_en == $past(frame_word[CMD_ULD_EN])
         && st.overvoltage_shutdown_enable_en == $past(frame_word[CMD_OVERVOLTAGE_SHUTDOWN_ENABLE_EN])))
    else $error("valid frame not applied");

  // sticky fault flags; a clear or a sleep or lockout wipe is the only way out
  AST_OLD_SET: assert property (
    |(oc_s & st.drive) && !hold |=> st.old)
    else $error("overload bit not set");
  AST_OLD_STICKY: assert property (
    st.old && !clr && !hold |=> st.old)
    else $error("overload bit lost without clear");
  AST_ULD_FLAG: assert property (
    |uld_hit && !hold |=> st.underload_shutdown_and_status)
    else $error("under-load flag not set");
  AST_ULD_STICKY: assert property (
    st.underload_shutdown_and_status && !clr && !hold |=> st.underload_shutdown_and_status)
    else $error("under-load bit lost without clear");
  AST_PSF_SET: assert property (
    (ova_s || ovb_s) && !hold |=> st.supply_fail_status)
    else $error("supply fail bit not set");
  AST_PSF_STICKY: assert property (
    st.supply_fail_status && !clr && !hold |=> st.supply_fail_status)
    else $error("supply fail bit lost without clear");
  AST_TW_SET: assert property (
    |warn_s && !hold |=> st.tw)
    else $error("warning bit not set");
  AST_TW_STICKY: assert property (
    st.tw && !clr && !hold |=> st.tw)
    else $error("warning bit dropped without clear");

  // latches and gates; gates must give the programmed pattern back
  AST_OCD_LATCH: assert property (
    (st.ocd_en && |(oc_s & st.drive) && !hold)
    |=> ((st.latched_off & $past(oc_s & st.drive)) == $past(oc_s & st.drive)))
    else $error("overcurrent output not latched off");
  AST_ULD_LATCH: assert property (
    (st.uld_en && |uld_hit && !hold)
    |=> ((st.latched_off & $past(uld_hit)) == $past(uld_hit)))
    else $error("under-load output not latched off");
  AST_NO_LATCH_DISABLED: assert property (
    (!st.ocd_en && !st.uld_en && !clr && !hold) |=> st.latched_off == $past(st.latched_off))
    else $error("output latched off with shutdown disabled");
  AST_OT_ALL_OFF: assert property (
    |ot_s |=> st.drive == '0)
    else $error("output on above over-temperature");
  AST_OT_RESTORE: assert property (
    (|ot_s && !hold)
    ##1 (!(|ot_s) && !uv_s && !ova_s && !ovb_s && !hold && !frame_ok && !(|oc_s)
         && !(|uld_hit))
    |=> st.drive == (st.prog & ~st.latched_off))
    else $error("pattern not restored after cooling");
  AST_OV_GATE: assert property (
    (st.overvoltage_shutdown_enable_en && ova_s && !frame_ok) |=> st.drive == '0)
    else $error("outputs on during overvoltage");
  AST_OV_RESTORE: assert property (
    (st.overvoltage_shutdown_enable_en && ova_s && !ovb_s && !uv_s && !hold)
    ##1 (!ova_s && !ovb_s && !uv_s && !(|ot_s) && !hold && !frame_ok && !(|oc_s)
         && !(|uld_hit))
    |=> st.drive == (st.prog & ~st.latched_off))
    else $error("pattern not restored after overvoltage");
  AST_CLEAR_FREES: assert property (
    (clr && !(|oc_s) && !(|uld_hit) && !hold) |=> st.latched_off == '0)
    else $error("status clear left outputs latched");
  AST_CLEAR_FLAGS: assert property (
    (clr && !hold && !(|(oc_s & st.drive)) && !(|uld_hit) && !ova_s && !ovb_s && !uv_s
     && !(|warn_s)) |=> (!st.old && !st.underload_shutdown_and_status && !st.supply_fail_status && !st.tw))
    else $error("status clear left a flag set");

  // main scenarios
  COV_OT_TOGGLE: cover property (|ot_s ##1 !(|ot_s) ##2 st.drive != '0);
  COV_OCD_TRIP:  cover property (st.ocd_en && |(oc_s & st.drive) ##1 st.old);
  COV_ULD_LATCH: cover property (st.uld_en && |uld_hit ##1 st.latched_off != '0);
  COV_CLEAR:     cover property (clr && st.old);
endmodule : hex_half_bridge_fault_control
`default_nettype wire

// ==== verif/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// serial master standing in for the host controller
module host_model (
  output logic      chip_select_n,
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  // idle: select pulled up, clock and data pulled down, clock stopped
  initial begin
    chip_select_n = 1'b1;
    sclk          = 1'b0;
    sdi           = 1'b0;
  end

  // drop high side of any pair whose low side is also asked on
  function automatic logic [15:0] safe(input logic [15:0] w);
    for (int k = 0; k < 6; k++) begin
      if (w[2*k+1] && w[2*k+2]) begin
        w[2*k+2] = 1'b0;
      end
    end
    return w;
  endfunction : safe

  // one frame of nb bits, lsb first; data moves on the rising edge so it is
  // steady across the falling edge where the device samples it
  task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    logic [31:0] w;
    w = {safe(tx[31:16]), safe(tx[15:0])};
    rx = '0;
    chip_select_n = 1'b0;
    #80;
    for (int i = 0; i < nb; i++) begin
      sclk = 1'b1;
      sdi  = w[i];
      #80;
      // the device moves sdo on the rise, so read it just before the fall
      rx[i] = sdo;
      sclk  = 1'b0;
      #80;
    end
    chip_select_n = 1'b1;
    sdi = 1'b0;
    #300; // select high time with margin
  endtask : xfer

  // select pulse without clocks, returns {sdo_oe, sdo}
  task automatic peek(output logic [1:0] v);
    chip_select_n = 1'b0;
    #40 v = {sdo_oe, sdo};
    chip_select_n = 1'b1;
    #300;
  endtask : peek
endmodule : host_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
  import hbr_pkg::*;
  logic        mclk, rst, sleep_enable, logic_supply_ok, undervoltage_lockout;
  logic        driver_supply_a_ov, driver_supply_b_ov;
  logic [11:0] overcurrent, underload;
  logic [5:0]  thermal_warning, over_temperature, high_side_output, low_side_output;
  logic        chip_select_n, sclk, sdi, sdo, sdo_oe;
  logic [15:0] rx;
  logic [31:0] r32;
  logic [1:0]  pk;
  int          n_mismatch = 0;
  int          n_checks = 0;

  hex_half_bridge_fault_control #(.ULD_DELAY_NS(50)) i_dut (
    .mclk(mclk), .rst(rst), .sleep_enable(sleep_enable),
    .logic_supply_ok(logic_supply_ok), .undervoltage_lockout(undervoltage_lockout),
    .driver_supply_a_ov(driver_supply_a_ov), .driver_supply_b_ov(driver_supply_b_ov),
    .overcurrent(overcurrent), .underload(underload), .thermal_warning(thermal_warning),
    .over_temperature(over_temperature), .chip_select_n(chip_select_n), .sclk(sclk),
    .sdi(sdi), .high_side_output(high_side_output), .low_side_output(low_side_output),
    .sdo(sdo), .sdo_oe(sdo_oe));

  host_model i_host (
    .chip_select_n(chip_select_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  // 200 MHz clock
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // outputs folded back into command bit positions
  function automatic logic [15:0] outs();
    logic [15:0] o;
    o = '0;
    for (int k = 0; k < 6; k++) begin
      o[2*k+1] = low_side_output[k];
      o[2*k+2] = high_side_output[k];
    end
    return o;
  endfunction : outs

  // inputs settle through the synchronisers before anything is judged
  task automatic wt(input int n = 12);
    repeat (n) @(negedge mclk);
  endtask : wt

  task automatic wr(input logic [15:0] c);
    i_host.xfer({16'h0000, c}, 16, r32);
    rx = r32[15:0];
  endtask : wr

  task automatic t_io();
    chk("outs after reset", outs(), 16'h0000);
    chk("sdo_oe idle", sdo_oe, 1'b0);
    wr(16'h0AAA);
    chk("low sides", outs(), 16'h0AAA);
    wr(16'h1554);
    chk("status mirror", rx, 16'h0AAA);
    chk("high sides", outs(), 16'h1554);
  endtask : t_io

  task automatic t_frames();
    i_host.xfer(32'h0AAA_0002, 32, r32);
    chk("daisy chain", r32, 32'h0002_1554);
    chk("last word applied", outs(), 16'h0AAA);
    i_host.xfer(32'h0000_0002, 8, r32);
    chk("short frame", outs(), 16'h0AAA);
  endtask : t_frames

  task automatic t_warn();
    @(negedge mclk) thermal_warning = 6'h04;
    wt();
    chk("outs in warning", outs(), 16'h0AAA);
    i_host.peek(pk);
    chk("early warning", pk, 2'b11);
    chk("sdo_oe after select", sdo_oe, 1'b0);
    @(negedge mclk) thermal_warning = 6'h00;
    wt();
    i_host.peek(pk);
    chk("warning latched", pk, 2'b11);
    wr(16'h0AAB);
    wr(16'h0AAA);
    chk("warning cleared", rx, 16'h0AAA);
    i_host.peek(pk);
    chk("no warning", pk, 2'b10);
  endtask : t_warn

  task automatic t_ocur();
    @(negedge mclk) overcurrent = 12'h001;
    wt();
    chk("ocd off keeps", outs(), 16'h0AAA);
    wr(16'h2AAA);
    chk("overload flag", rx, 16'h2AAA);
    chk("ocd latch off", outs(), 16'h0AA8);
    @(negedge mclk) overcurrent = 12'h000;
    wt();
    chk("latch holds", outs(), 16'h0AA8);
    wr(16'h0AAB);
    chk("status off bit", rx, 16'h2AA8);
    chk("clear releases", outs(), 16'h0AAA);
    wr(16'h0AAA);
    chk("overload cleared", rx, 16'h0AAA);
  endtask : t_ocur

  task automatic t_uload();
    @(negedge mclk) underload = 12'h004;
    wt(30);
    chk("uld off keeps", outs(), 16'h0AAA);
    wr(16'h4AAA);
    chk("underload flag", rx, 16'h4AAA);
    wt(30);
    chk("uld latch off", outs(), 16'h0AA2);
    @(negedge mclk) underload = 12'h000;
    wr(16'h0AAB);
    chk("uld released", outs(), 16'h0AAA);
  endtask : t_uload

  task automatic t_ovolt();
    wr(16'h8AAA);
    @(negedge mclk) driver_supply_a_ov = 1'b1;
    wt();
    chk("ov gates all", outs(), 16'h0000);
    @(negedge mclk) driver_supply_a_ov = 1'b0;
    wt();
    chk("ov restores", outs(), 16'h0AAA);
    wr(16'h0AAA);
    chk("supply fail flag", rx, 16'h8AAA);
    @(negedge mclk) driver_supply_b_ov = 1'b1;
    wt();
    chk("ov disabled", outs(), 16'h0AAA);
    @(negedge mclk) driver_supply_b_ov = 1'b0;
  endtask : t_ovolt

  task automatic t_temp();
    @(negedge mclk) over_temperature = 6'h20;
    wt();
    chk("hot all off", outs(), 16'h0000);
    wr(16'h1554);
    chk("no turn on hot", outs(), 16'h0000);
    @(negedge mclk) over_temperature = 6'h00;
    wt();
    chk("cool resumes", outs(), 16'h1554);
    @(negedge mclk) undervoltage_lockout = 1'b1;
    wt();
    chk("undervoltage off", outs(), 16'h0000);
    @(negedge mclk) undervoltage_lockout = 1'b0;
    wt();
    chk("state kept", outs(), 16'h1554);
  endtask : t_temp

  task automatic t_sleep();
    @(negedge mclk) sleep_enable = 1'b0;
    wt();
    chk("sleep off", outs(), 16'h0000);
    @(negedge mclk) sleep_enable = 1'b1;
    wt();
    chk("wake off", outs(), 16'h0000);
    wr(16'h0000);
    chk("status lost", rx, 16'h0000);
    @(negedge mclk) logic_supply_ok = 1'b0;
    wt();
    wr(16'h1554);
    @(negedge mclk) logic_supply_ok = 1'b1;
    wt();
    chk("lockout drops frame", outs(), 16'h0000);
    wr(16'h1554);
    chk("frame after lockout", outs(), 16'h1554);
  endtask : t_sleep

  // main sequence; all inputs set at time zero
  initial begin
    rst = 1'b1;
    sleep_enable = 1'b1;
    logic_supply_ok = 1'b1;
    undervoltage_lockout = 1'b0;
    driver_supply_a_ov = 1'b0;
    driver_supply_b_ov = 1'b0;
    overcurrent = '0;
    underload = '0;
    thermal_warning = '0;
    over_temperature = '0;
    wt(5);
    rst = 1'b0;
    wt(10);
    t_io();
    t_frames();
    t_warn();
    t_ocur();
    t_uload();
    t_ovolt();
    t_temp();
    t_sleep();
    stop_test();
  end

  // hang guard, well beyond the expected run of about 55 us
  initial begin
    #400_000;
    n_mismatch++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
